// ---- hw/gpt_timer.v ----
// General purpose timer with joined 32-bit timer and clock modes, AXI4-Lite registers.
//
// Added by the designer: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`include "gpt_timer_defs.vh"

module gpt_timer #(
  parameter [15:0] RTC_DIV = `GPT_RTC_DIV
) (
  input  wire        MCLK_I,
  input  wire        RESET_I,
  input  wire        CCP_I,
  input  wire        DEBUG_HALT_I,
  output reg         TRIGGER_O,
  output reg         IRQ_O,
  input  wire [7:0]  S_AXI_AWADDR_I,
  input  wire        S_AXI_AWVALID_I,
  output reg         S_AXI_AWREADY_O,
  input  wire [31:0] S_AXI_WDATA_I,
  input  wire [3:0]  S_AXI_WSTRB_I,
  input  wire        S_AXI_WVALID_I,
  output reg         S_AXI_WREADY_O,
  output reg  [1:0]  S_AXI_BRESP_O,
  output reg         S_AXI_BVALID_O,
  input  wire        S_AXI_BREADY_I,
  input  wire [7:0]  S_AXI_ARADDR_I,
  input  wire        S_AXI_ARVALID_I,
  output reg         S_AXI_ARREADY_O,
  output reg  [31:0] S_AXI_RDATA_O,
  output reg  [1:0]  S_AXI_RRESP_O,
  output reg         S_AXI_RVALID_O,
  input  wire        S_AXI_RREADY_I
);

  localparam [15:0] DIV_LAST = RTC_DIV - 16'h0001;

  ////////////////////////////////////////////////////////////////////////////////
  // Register state.

  reg  [2:0]  cfg_q;
  reg  [1:0]  amode_q;
  reg  [1:0]  bmode_q;
  reg  [15:0] ctl_q;
  reg  [3:0]  imr_q;
  reg  [3:0]  ris_q;
  reg  [15:0] ila_q;
  reg  [15:0] ilb_q;
  reg  [31:0] amatch_q;
  reg  [7:0]  apr_q;
  reg  [7:0]  bpr_q;
  reg  [31:0] cnt_q;
  reg         load_pend_q;
  reg         rtc_init_q;
  reg         ccp_prev_q;
  reg  [15:0] div_q;

  reg         aw_got_q;
  reg         w_got_q;
  reg  [7:0]  waddr_q;
  reg  [31:0] wdata_q;
  reg  [3:0]  wstrb_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Helpers.

  function [31:0] merge;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0]  strb;
    integer      i;
    begin
      merge = old_v;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i]) begin
          merge[i*8 +: 8] = new_v[i*8 +: 8];
        end
      end
    end
  endfunction

  function mapped;
    input [7:0] addr;
    begin
      case (addr)
        `GPT_OFF_CFG, `GPT_OFF_AMODE, `GPT_OFF_BMODE, `GPT_OFF_CTL,
        `GPT_OFF_IMR, `GPT_OFF_RIS, `GPT_OFF_MIS, `GPT_OFF_ICR,
        `GPT_OFF_AILR, `GPT_OFF_BILR, `GPT_OFF_AMATCH, `GPT_OFF_APR,
        `GPT_OFF_BPR, `GPT_OFF_ACNT, `GPT_OFF_BCNT: mapped = 1'b1;
        default: mapped = 1'b0;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Bus handshake.

  wire aw_hs    = S_AXI_AWVALID_I & S_AXI_AWREADY_O;
  wire w_hs     = S_AXI_WVALID_I & S_AXI_WREADY_O;
  wire ar_hs    = S_AXI_ARVALID_I & S_AXI_ARREADY_O;
  wire do_write = aw_got_q & w_got_q & ~S_AXI_BVALID_O;

  wire aw_got_d = ~do_write & (aw_got_q | aw_hs);
  wire w_got_d  = ~do_write & (w_got_q | w_hs);
  wire bvalid_d = do_write | (S_AXI_BVALID_O & ~S_AXI_BREADY_I);
  wire rvalid_d = ar_hs | (S_AXI_RVALID_O & ~S_AXI_RREADY_I);

  wire [31:0] wmerge = merge(32'h00000000, wdata_q, wstrb_q);
  // Unstrobed byte lanes keep what the register already holds.
  wire [31:0] ctl_m   = merge({16'h0000, ctl_q}, wdata_q, wstrb_q);
  wire [31:0] il_m    = merge({ilb_q, ila_q}, wdata_q, wstrb_q);
  wire [31:0] ilb_m   = merge({16'h0000, ilb_q}, wdata_q, wstrb_q);
  wire        wr_cfg  = do_write & (waddr_q == `GPT_OFF_CFG);
  wire        wr_ctl  = do_write & (waddr_q == `GPT_OFF_CTL);
  wire        wr_icr  = do_write & (waddr_q == `GPT_OFF_ICR);
  wire        wr_ailr = do_write & (waddr_q == `GPT_OFF_AILR);
  wire        wr_bilr = do_write & (waddr_q == `GPT_OFF_BILR);

  ////////////////////////////////////////////////////////////////////////////////
  // Mode decode.

  wire mode_tmr = (cfg_q == `GPT_CFG_32TMR);
  wire mode_rtc = (cfg_q == `GPT_CFG_32RTC);
  wire joined   = mode_tmr | mode_rtc;
  wire a_en     = ctl_q[`GPT_CTL_AEN];
  wire oneshot  = (amode_q == `GPT_MODE_ONESHOT);
  wire tmr_mode = oneshot | (amode_q == `GPT_MODE_PERIOD);
  wire tmr_stall = DEBUG_HALT_I & ctl_q[`GPT_CTL_ASTALL];
  wire rtc_stall = DEBUG_HALT_I & (ctl_q[`GPT_CTL_ASTALL] | ctl_q[`GPT_CTL_BSTALL])
                   & ~ctl_q[`GPT_CTL_OVR];
  wire tmr_run  = mode_tmr & tmr_mode & a_en & ~tmr_stall;
  wire rtc_run  = mode_rtc & a_en & ~rtc_stall;
  wire ccp_rise = CCP_I & ~ccp_prev_q;
  wire tick     = rtc_run & ccp_rise & (div_q == DIV_LAST);
  wire tmr_zero = tmr_run & ~load_pend_q & (cnt_q == 32'h00000000);
  wire rtc_hit  = tick & ~rtc_init_q & (cnt_q == amatch_q);

  reg  [3:0] ris_set;
  always @* begin
    ris_set = 4'h0;
    ris_set[`GPT_INT_ATO] = tmr_zero;
    ris_set[`GPT_INT_CLK] = rtc_hit;
  end

  // clear by ones, set wins over clear
  wire [3:0] ris_d = ris_set | (ris_q & ~(wr_icr ? wmerge[3:0] : 4'h0));

  ////////////////////////////////////////////////////////////////////////////////
  // Bus slave registers.

  always @(posedge MCLK_I) begin
    if (RESET_I) begin
      aw_got_q        <= 1'b0;
      w_got_q         <= 1'b0;
      waddr_q         <= 8'h00;
      wdata_q         <= 32'h00000000;
      wstrb_q         <= 4'h0;
      S_AXI_AWREADY_O <= 1'b0;
      S_AXI_WREADY_O  <= 1'b0;
      S_AXI_BVALID_O  <= 1'b0;
      S_AXI_BRESP_O   <= `GPT_RESP_OKAY;
      S_AXI_ARREADY_O <= 1'b0;
      S_AXI_RVALID_O  <= 1'b0;
      S_AXI_RRESP_O   <= `GPT_RESP_OKAY;
      S_AXI_RDATA_O   <= 32'h00000000;
    end else begin
      aw_got_q        <= aw_got_d;
      w_got_q         <= w_got_d;
      S_AXI_AWREADY_O <= ~aw_got_d & ~bvalid_d;
      S_AXI_WREADY_O  <= ~w_got_d & ~bvalid_d;
      S_AXI_BVALID_O  <= bvalid_d;
      S_AXI_ARREADY_O <= ~rvalid_d;
      S_AXI_RVALID_O  <= rvalid_d;
      if (aw_hs) begin
        waddr_q <= {S_AXI_AWADDR_I[7:2], 2'b00};
      end
      if (w_hs) begin
        wdata_q <= S_AXI_WDATA_I;
        wstrb_q <= S_AXI_WSTRB_I;
      end
      if (do_write) begin
        S_AXI_BRESP_O <= mapped(waddr_q) ? `GPT_RESP_OKAY : `GPT_RESP_SLVERR;
      end
      if (ar_hs) begin
        S_AXI_RRESP_O <= mapped({S_AXI_ARADDR_I[7:2], 2'b00}) ? `GPT_RESP_OKAY
                                                             : `GPT_RESP_SLVERR;
        case ({S_AXI_ARADDR_I[7:2], 2'b00})
          `GPT_OFF_CFG:    S_AXI_RDATA_O <= {29'h0, cfg_q};
          `GPT_OFF_AMODE:  S_AXI_RDATA_O <= {30'h0, amode_q};
          `GPT_OFF_BMODE:  S_AXI_RDATA_O <= {30'h0, bmode_q};
          `GPT_OFF_CTL:    S_AXI_RDATA_O <= {16'h0, ctl_q};
          `GPT_OFF_IMR:    S_AXI_RDATA_O <= {28'h0, imr_q};
          `GPT_OFF_RIS:    S_AXI_RDATA_O <= {28'h0, ris_q};
          `GPT_OFF_MIS:    S_AXI_RDATA_O <= {28'h0, ris_q & imr_q};
          `GPT_OFF_AILR:   S_AXI_RDATA_O <= joined ? {ilb_q, ila_q} : {16'h0, ila_q};
          `GPT_OFF_BILR:   S_AXI_RDATA_O <= {16'h0, ilb_q};
          `GPT_OFF_AMATCH: S_AXI_RDATA_O <= amatch_q;
          `GPT_OFF_APR:    S_AXI_RDATA_O <= {24'h0, apr_q};
          `GPT_OFF_BPR:    S_AXI_RDATA_O <= {24'h0, bpr_q};
          `GPT_OFF_ACNT:   S_AXI_RDATA_O <= joined ? cnt_q : {16'h0, cnt_q[15:0]};
          `GPT_OFF_BCNT:   S_AXI_RDATA_O <= {16'h0, cnt_q[31:16]};
          default:         S_AXI_RDATA_O <= 32'h00000000;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Software configuration registers.

  always @(posedge MCLK_I) begin
    if (RESET_I) begin
      cfg_q    <= 3'h0;
      amode_q  <= 2'h0;
      bmode_q  <= 2'h0;
      imr_q    <= 4'h0;
      amatch_q <= 32'hFFFFFFFF;
      ila_q    <= `GPT_ILR_RST;
      ilb_q    <= `GPT_ILR_RST;
      apr_q    <= `GPT_PR_RST;
      bpr_q    <= `GPT_PR_RST;
    end else if (do_write) begin
      case (waddr_q)
        `GPT_OFF_CFG:    cfg_q    <= wstrb_q[0] ? wdata_q[2:0] : cfg_q;
        `GPT_OFF_AMODE:  amode_q  <= wstrb_q[0] ? wdata_q[1:0] : amode_q;
        `GPT_OFF_BMODE:  bmode_q  <= wstrb_q[0] ? wdata_q[1:0] : bmode_q;
        `GPT_OFF_IMR:    imr_q    <= wstrb_q[0] ? wdata_q[3:0] : imr_q;
        `GPT_OFF_AMATCH: amatch_q <= merge(amatch_q, wdata_q, wstrb_q);
        `GPT_OFF_APR:    apr_q    <= wstrb_q[0] ? wdata_q[7:0] : apr_q;
        `GPT_OFF_BPR:    bpr_q    <= wstrb_q[0] ? wdata_q[7:0] : bpr_q;
        `GPT_OFF_AILR: begin
          ila_q <= il_m[15:0];
          // upper half fills half B load
          if (joined) begin
            ilb_q <= il_m[31:16];
          end
        end
        `GPT_OFF_BILR:   ilb_q    <= ilb_m[15:0];
        default: begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Counter, control and status.

  always @(posedge MCLK_I) begin
    if (RESET_I) begin
      cnt_q       <= {`GPT_CNT_RST, `GPT_CNT_RST};
      ctl_q       <= 16'h0000;
      ris_q       <= 4'h0;
      load_pend_q <= 1'b0;
      rtc_init_q  <= 1'b0;
      ccp_prev_q  <= 1'b0;
      div_q       <= 16'h0000;
      TRIGGER_O   <= 1'b0;
      IRQ_O       <= 1'b0;
    end else begin
      ccp_prev_q <= CCP_I;
      ris_q      <= ris_d;
      IRQ_O      <= |(ris_d & imr_q);
      TRIGGER_O  <= tmr_zero;
      if (wr_ctl) begin
        ctl_q <= ctl_m[15:0];
      end
      if (tmr_zero & oneshot) begin
        ctl_q[`GPT_CTL_AEN] <= 1'b0;
      end
      load_pend_q <= wr_ailr | wr_bilr;
      rtc_init_q  <= wr_cfg & (wmerge[2:0] == `GPT_CFG_32RTC) & ~mode_rtc;
      // The divider restarts whenever the clock is not running, so a
      // fresh enable always waits a full second for its first tick.
      if (!rtc_run) begin
        div_q <= 16'h0000;
      end else if (ccp_rise) begin
        div_q <= (div_q == DIV_LAST) ? 16'h0000 : div_q + 16'h0001;
      end
      if (rtc_init_q) begin
        cnt_q <= `GPT_RTC_START;
      end else if (mode_tmr & load_pend_q) begin
        cnt_q <= {ilb_q, ila_q};
      end else if (tmr_zero) begin
        cnt_q <= {ilb_q, ila_q};
      end else if (tmr_run) begin
        cnt_q <= cnt_q - 32'h00000001;
      end else if (rtc_hit) begin
        cnt_q <= 32'h00000000;
      end else if (tick) begin
        cnt_q <= cnt_q + 32'h00000001;
      end
    end
  end

endmodule // gpt_timer

// ---- hw/gpt_timer_defs.vh ----
// Constant definitions for the general purpose timer block.
`ifndef GPT_TIMER_DEFS_VH
`define GPT_TIMER_DEFS_VH

// Register byte offsets.
`define GPT_OFF_CFG      8'h00
`define GPT_OFF_AMODE    8'h04
`define GPT_OFF_BMODE    8'h08
`define GPT_OFF_CTL      8'h0C
`define GPT_OFF_IMR      8'h18
`define GPT_OFF_RIS      8'h1C
`define GPT_OFF_MIS      8'h20
`define GPT_OFF_ICR      8'h24
`define GPT_OFF_AILR     8'h28
`define GPT_OFF_BILR     8'h2C
`define GPT_OFF_AMATCH   8'h30
`define GPT_OFF_APR      8'h38
`define GPT_OFF_BPR      8'h3C
`define GPT_OFF_ACNT     8'h48
`define GPT_OFF_BCNT     8'h4C

// Control register fields.
`define GPT_CTL_AEN      0
`define GPT_CTL_ASTALL   1
`define GPT_CTL_OVR      4
`define GPT_CTL_BEN      8
`define GPT_CTL_BSTALL   9

// Interrupt status fields.
`define GPT_INT_ATO      0
`define GPT_INT_CLK      3

// Configuration and mode encodings.
`define GPT_CFG_32TMR    3'h0
`define GPT_CFG_32RTC    3'h1
`define GPT_MODE_ONESHOT 2'h1
`define GPT_MODE_PERIOD  2'h2

// Reset values, and the count loaded on entry to clock mode.
`define GPT_CNT_RST      16'hFFFF
`define GPT_ILR_RST      16'hFFFF
`define GPT_PR_RST       8'h00
`define GPT_RTC_START    32'h00000001

// Capture edges per one second tick of the clock mode.
`define GPT_RTC_DIV      16'h8000

// Bus responses.
`define GPT_RESP_OKAY    2'h0
`define GPT_RESP_SLVERR  2'h2

`endif

// ---- testbench/gpt_ccp_src.sv ----
// Square wave source standing in for the clock on the even capture pin.
`timescale 1ns/1ps
module gpt_ccp_src #(
  parameter real HALF_NS = 40.0
) (
  input  wire run_i,
  output reg  ccp_o
);
  // slow clock source
  // The rate is scaled up from the real source so that a divided tick fits a short run.
  initial begin
    ccp_o = 1'b0;
    forever begin
      #(HALF_NS);
      ccp_o = run_i ? ~ccp_o : 1'b0;
    end
  end
endmodule // gpt_ccp_src

// ---- testbench/gpt_timer_asserts.sv ----
// Concurrent checks on the timer block ports.
`timescale 1ns/1ps
module gpt_timer_chk #(
  parameter [15:0] RTC_DIV = 16'h8000
) (
  input wire        MCLK_I,
  input wire        RESET_I,
  input wire        TRIGGER_O,
  input wire        IRQ_O,
  input wire [7:0]  S_AXI_AWADDR_I,
  input wire        S_AXI_AWVALID_I,
  input wire        S_AXI_AWREADY_O,
  input wire        S_AXI_WVALID_I,
  input wire        S_AXI_WREADY_O,
  input wire [1:0]  S_AXI_BRESP_O,
  input wire        S_AXI_BVALID_O,
  input wire        S_AXI_BREADY_I,
  input wire [7:0]  S_AXI_ARADDR_I,
  input wire        S_AXI_ARVALID_I,
  input wire        S_AXI_ARREADY_O,
  input wire [31:0] S_AXI_RDATA_O,
  input wire [1:0]  S_AXI_RRESP_O,
  input wire        S_AXI_RVALID_O,
  input wire        S_AXI_RREADY_I
);
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (RESET_I);
  ////////////////////////////////////////////////////////////////////////////////
  sequence wr_taken;
    S_AXI_AWVALID_I && S_AXI_AWREADY_O && S_AXI_WVALID_I && S_AXI_WREADY_O;
  endsequence
  sequence rd_taken;
    S_AXI_ARVALID_I && S_AXI_ARREADY_O;
  endsequence
  chk_reset_quiet: assert property (disable iff (1'b0)
    RESET_I |=> !TRIGGER_O && !IRQ_O && !S_AXI_BVALID_O && !S_AXI_RVALID_O)
    else $error("outputs active after reset");
  chk_write_answer: assert property (
    wr_taken |=> !S_AXI_AWREADY_O && !S_AXI_WREADY_O ##1 S_AXI_BVALID_O)
    else $error("write response timing wrong");
  chk_unmapped_write: assert property (
    wr_taken and S_AXI_AWADDR_I == 8'h10 |=> ##1 S_AXI_BRESP_O == 2'h2)
    else $error("unmapped write not refused");
  chk_read_answer: assert property (
    rd_taken |=> S_AXI_RVALID_O && !S_AXI_ARREADY_O)
    else $error("read response timing wrong");
  chk_unmapped_read: assert property (
    rd_taken and S_AXI_ARADDR_I == 8'h10 |=> S_AXI_RRESP_O == 2'h2 && S_AXI_RDATA_O == 32'h0)
    else $error("unmapped read not refused");
  chk_rdata_hold: assert property (
    S_AXI_RVALID_O && !S_AXI_RREADY_I |=> S_AXI_RVALID_O && $stable(S_AXI_RDATA_O))
    else $error("read data not held");
  chk_read_release: assert property (
    S_AXI_RVALID_O && S_AXI_RREADY_I |=> !S_AXI_RVALID_O && S_AXI_ARREADY_O)
    else $error("read channel not released");
  chk_bvalid_drop: assert property (
    S_AXI_BVALID_O && S_AXI_BREADY_I |=> !S_AXI_BVALID_O ##[0:1] S_AXI_AWREADY_O && S_AXI_WREADY_O)
    else $error("write channel not released");
endmodule // gpt_timer_chk
bind gpt_timer gpt_timer_chk #(.RTC_DIV(RTC_DIV)) gpt_timer_chk_i (.MCLK_I(MCLK_I),
  .RESET_I(RESET_I), .TRIGGER_O(TRIGGER_O), .IRQ_O(IRQ_O), .S_AXI_AWADDR_I(S_AXI_AWADDR_I),
  .S_AXI_AWVALID_I(S_AXI_AWVALID_I), .S_AXI_AWREADY_O(S_AXI_AWREADY_O),
  .S_AXI_WVALID_I(S_AXI_WVALID_I), .S_AXI_WREADY_O(S_AXI_WREADY_O),
  .S_AXI_BRESP_O(S_AXI_BRESP_O), .S_AXI_BVALID_O(S_AXI_BVALID_O),
  .S_AXI_BREADY_I(S_AXI_BREADY_I), .S_AXI_ARADDR_I(S_AXI_ARADDR_I),
  .S_AXI_ARVALID_I(S_AXI_ARVALID_I), .S_AXI_ARREADY_O(S_AXI_ARREADY_O),
  .S_AXI_RDATA_O(S_AXI_RDATA_O), .S_AXI_RRESP_O(S_AXI_RRESP_O),
  .S_AXI_RVALID_O(S_AXI_RVALID_O), .S_AXI_RREADY_I(S_AXI_RREADY_I));

// ---- testbench/gpt_timer_tb.sv ----
// Self-checking register level testbench for the timer block.
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module gpt_timer_tb;
  reg         mclk, rst, run, halt, awvalid, wvalid, bready, arvalid, rready;
  reg  [7:0]  awaddr, araddr;
  reg  [31:0] wdata, rd_data, a;
  reg  [1:0]  wr_resp, rd_resp;
  wire        ccp, trig, irq, awready, wready, bvalid, arready, rvalid;
  wire [1:0]  bresp, rresp;
  wire [31:0] rdata;
  int         error_cnt, num_checks, trig_cnt, cyc, t_last, t_prev;
  ////////////////////////////////////////////////////////////////////////////////
  gpt_ccp_src gpt_ccp_src_i (.run_i(run), .ccp_o(ccp));
  gpt_timer #(.RTC_DIV(16'h0004)) gpt_timer_i (.MCLK_I(mclk), .RESET_I(rst), .CCP_I(ccp),
    .DEBUG_HALT_I(halt), .TRIGGER_O(trig), .IRQ_O(irq), .S_AXI_AWADDR_I(awaddr),
    .S_AXI_AWVALID_I(awvalid), .S_AXI_AWREADY_O(awready), .S_AXI_WDATA_I(wdata),
    .S_AXI_WSTRB_I(4'hF), .S_AXI_WVALID_I(wvalid), .S_AXI_WREADY_O(wready),
    .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid), .S_AXI_BREADY_I(bready),
    .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid), .S_AXI_ARREADY_O(arready),
    .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rvalid),
    .S_AXI_RREADY_I(rready));
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (trig === 1'b1) begin
      trig_cnt <= trig_cnt + 1;
      t_prev <= t_last;
      t_last <= cyc;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task wr(input [7:0] ad, input [31:0] d);
    reg aw_ok;
    reg w_ok;
    @(posedge mclk);
    awaddr <= ad;
    awvalid <= 1'b1;
    wdata <= d;
    wvalid <= 1'b1;
    bready <= 1'b1;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    while (!(aw_ok && w_ok)) begin
      @(posedge mclk);
      if (awvalid && awready === 1'b1) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready === 1'b1) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge mclk); while (bvalid !== 1'b1);
    wr_resp = bresp;
    bready <= 1'b0;
  endtask
  // A slow read leaves the answer waiting, which proves that it stays put.
  task rd(input [7:0] ad, input bit slow);
    @(posedge mclk);
    araddr <= ad;
    arvalid <= 1'b1;
    rready <= !slow;
    do @(posedge mclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    if (slow) begin
      repeat (3) @(posedge mclk);
      rready <= 1'b1;
    end
    do @(posedge mclk); while (rvalid !== 1'b1 || rready !== 1'b1);
    rd_data = rdata;
    rd_resp = rresp;
    rready <= 1'b0;
  endtask
  task chk(input [7:0] ad, input [31:0] e);
    rd(ad, 1'b0);
    `CHK(rd_data, e)
  endtask
  task report_and_stop;
    $display("errors=%0d checks=%0d", error_cnt, num_checks);
    if (error_cnt == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    #200000;
    error_cnt++;
    report_and_stop;
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {run, halt, awvalid, wvalid, bready, arvalid, rready} = 7'h00;
    {awaddr, araddr, wdata, cyc, trig_cnt, t_last, t_prev} = 0;
    rst = 1'b1;
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    chk(8'h48, 32'hFFFFFFFF);
    chk(8'h4C, 32'h0000FFFF);
    chk(8'h2C, 32'h0000FFFF);
    chk(8'h38, 32'h00000000);
    chk(8'h3C, 32'h00000000);
    chk(8'h0C, 32'h00000000);
    chk(8'h1C, 32'h00000000);
    wr(8'h10, 32'h00000001);
    `CHK(wr_resp, 2'h2)
    rd(8'h10, 1'b1);
    `CHK(rd_resp, 2'h2)
    `CHK(rd_data, 32'h00000000)
    chk(8'h48, 32'hFFFFFFFF);
    wr(8'h28, 32'h00020005);
    chk(8'h2C, 32'h00000002);
    chk(8'h48, 32'h00020005);
    wr(8'h08, 32'h00000002);
    wr(8'h04, 32'h00000001);
    wr(8'h28, 32'h00000010);
    wr(8'h18, 32'h00000001);
    wr(8'h0C, 32'h00000001);
    wait (trig_cnt == 1);
    repeat (40) @(posedge mclk);
    `CHK(trig_cnt, 1)
    chk(8'h0C, 32'h00000000);
    chk(8'h48, 32'h00000010);
    chk(8'h1C, 32'h00000001);
    chk(8'h20, 32'h00000001);
    `CHK(irq, 1'b1)
    wr(8'h24, 32'h00000001);
    chk(8'h1C, 32'h00000000);
    chk(8'h24, 32'h00000000);
    `CHK(irq, 1'b0)
    wr(8'h04, 32'h00000002);
    wr(8'h0C, 32'h00000001);
    wait (trig_cnt == 3);
    `CHK(t_last - t_prev, 17)
    wr(8'h28, 32'h00001000);
    rd(8'h48, 1'b0);
    `CHK(rd_data <= 32'h00001000 && rd_data > 32'h00000FC0, 1'b1)
    wr(8'h0C, 32'h00000003);
    halt <= 1'b1;
    rd(8'h48, 1'b0);
    a = rd_data;
    chk(8'h48, a);
    halt <= 1'b0;
    rd(8'h48, 1'b0);
    `CHK(rd_data < a, 1'b1)
    wr(8'h0C, 32'h00000000);
    wr(8'h24, 32'h00000001);
    wr(8'h00, 32'h00000001);
    chk(8'h48, 32'h00000001);
    wr(8'h30, 32'h00000002);
    wr(8'h18, 32'h00000008);
    run <= 1'b1;
    wr(8'h0C, 32'h00000001);
    wait (irq === 1'b1);
    chk(8'h48, 32'h00000000);
    chk(8'h1C, 32'h00000008);
    chk(8'h20, 32'h00000008);
    wr(8'h30, 32'h00000100);
    wr(8'h0C, 32'h00000013);
    halt <= 1'b1;
    rd(8'h48, 1'b0);
    a = rd_data;
    repeat (200) @(posedge mclk);
    rd(8'h48, 1'b0);
    `CHK(rd_data > a, 1'b1)
    wr(8'h24, 32'h00000008);
    chk(8'h1C, 32'h00000000);
    chk(8'h20, 32'h00000000);
    // A reset in mid-run must bring a running clock back to the idle defaults.
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    chk(8'h48, 32'hFFFFFFFF);
    chk(8'h2C, 32'h0000FFFF);
    chk(8'h0C, 32'h00000000);
    chk(8'h00, 32'h00000000);
    report_and_stop;
  end
endmodule // gpt_timer_tb
